//--- fcs_pkg.sv
// Constants for the port 2 flow-control strap default loader
package fcs_pkg;
	// Strap vector field positions
	localparam int STRAP_W = 4;
	localparam int STRAP_BP_BIT = 0;
	localparam int STRAP_DUP_BIT = 1;
	localparam int STRAP_FORCED_BIT = 2;
	localparam int STRAP_FX_BIT = 3;
	// Strap reset values (used until the pins have been sampled)
	localparam logic [STRAP_W-1:0] STRAP_RESET = 4'h3;
	// Flow-control write word field positions
	localparam int FC_W = 4;
	localparam int FC_BP_BIT = 0;
	localparam int FC_TX_BIT = 1;
	localparam int FC_RX_BIT = 2;
	localparam int FC_FORCED_BIT = 3;
	// Advertisement write word field positions
	localparam int ADV_W = 2;
	localparam int ADV_SYM_BIT = 0;
	localparam int ADV_ASYM_BIT = 1;
	// Reset values of the held bits, and the fiber-mode advertisement default
	localparam logic BP_DEFAULT = 1'h1;
	localparam logic DUP_DEFAULT = 1'h1;
	localparam logic FORCED_DEFAULT = 1'h0;
	localparam logic SYM_AUTO_DEFAULT = 1'h1;
	localparam logic FX_ADV_DEFAULT = 1'h0;
	// Load timing: cycles after reset release until the synchronised straps are taken
	localparam logic [1:0] LOAD_AT = 2'h2;
	// Loader states
	typedef enum logic [1:0] {FCS_SETTLE, FCS_LOADED} fcs_state_t;
endpackage

//--- fcs_strap_if.sv
// Carrier for the synchronised strap levels
`timescale 1ns/1ps
interface fcs_strap_if;
	import fcs_pkg::*;
	// Strap levels after two flip-flops
	logic [STRAP_W-1:0] level;
	modport source (output level);
	modport sink (input level);
endinterface

//--- fcs_sync.sv
// Two-stage synchroniser for the strap pins
`timescale 1ns/1ps
module fcs_sync
	import fcs_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic [STRAP_W-1:0] pins_in,
	fcs_strap_if.source strap
);
	// First stage, read only by the second stage
	logic [STRAP_W-1:0] meta_q;
	// Second stage, safe to use
	logic [STRAP_W-1:0] stable_q;

	////////////////////////////////////////////////////////////////
	// Two flip-flops per pin
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			meta_q <= STRAP_RESET;
			stable_q <= STRAP_RESET;
		end else begin
			meta_q <= pins_in;
			stable_q <= meta_q;
		end
	end

	assign strap.level = stable_q;
endmodule

//--- fcs_top.sv
// Port 2 flow-control and pause advertisement strap default loader
`timescale 1ns/1ps
module fcs_top
	import fcs_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic port2_backpressure_default_select_in,
	input wire logic port2_duplex_pause_default_select_in,
	input wire logic port2_forced_pause_default_select_in,
	input wire logic phy_fx_mode_in,
	input wire logic fc_wr_in,
	input wire logic [FC_W-1:0] fc_wdata_in,
	input wire logic adv_wr_in,
	input wire logic [ADV_W-1:0] adv_wdata_in,
	output logic port2_backpressure_enable_out,
	output logic port2_pause_transmit_enable_out,
	output logic port2_pause_receive_enable_out,
	output logic port2_forced_pause_select_out,
	output logic adv_sym_pause_out,
	output logic adv_asym_pause_out,
	output logic load_done_out
);
	////////////////////////////////////////////////////////////////
	// Strap synchronisation
	fcs_strap_if strap_bus ();
	// Strap pins gathered into one vector
	logic [STRAP_W-1:0] pins;
	assign pins = {phy_fx_mode_in, port2_forced_pause_default_select_in,
		port2_duplex_pause_default_select_in, port2_backpressure_default_select_in};

	fcs_sync u_sync (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.pins_in(pins),
		.strap(strap_bus.source)
	);

	// Named views of the synchronised straps
	logic bp_strap;
	logic dup_strap;
	logic forced_strap;
	logic fx_mode;
	assign bp_strap = strap_bus.level[STRAP_BP_BIT];
	assign dup_strap = strap_bus.level[STRAP_DUP_BIT];
	assign forced_strap = strap_bus.level[STRAP_FORCED_BIT];
	assign fx_mode = strap_bus.level[STRAP_FX_BIT];

	////////////////////////////////////////////////////////////////
	// Load sequencing
	// Loader state
	fcs_state_t state_q;
	// Cycles since reset release
	logic [1:0] settle_q;
	// One-cycle load strobe
	logic load;
	assign load = (state_q == FCS_SETTLE) && (settle_q == LOAD_AT);

	// Counts until the synchroniser holds real pin levels
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			settle_q <= 2'h0;
		end else if (state_q == FCS_SETTLE && settle_q != LOAD_AT) begin
			settle_q <= settle_q + 2'h1;
		end
	end

	// Settle, then load once and stay loaded until reset
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			state_q <= FCS_SETTLE;
		end else begin
			case (state_q)
				FCS_SETTLE: begin
					if (load) begin
						state_q <= FCS_LOADED;
					end
				end
				default: begin
					state_q <= FCS_LOADED;
				end
			endcase
		end
	end

	// Writes count only once the defaults are in place
	logic fc_wr;
	logic adv_wr;
	assign fc_wr = fc_wr_in && (state_q == FCS_LOADED);
	assign adv_wr = adv_wr_in && (state_q == FCS_LOADED);

	////////////////////////////////////////////////////////////////
	// Switch port 2 flow-control bits
	logic bp_q;
	logic tx_q;
	logic rx_q;
	logic forced_q;

	// Backpressure enable
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			bp_q <= BP_DEFAULT;
		end else if (load) begin
			bp_q <= bp_strap;
		end else if (fc_wr) begin
			bp_q <= fc_wdata_in[FC_BP_BIT];
		end
	end

	// Pause transmit and receive enables
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			tx_q <= DUP_DEFAULT;
			rx_q <= DUP_DEFAULT;
		end else if (load) begin
			tx_q <= dup_strap;
			rx_q <= dup_strap;
		end else if (fc_wr) begin
			tx_q <= fc_wdata_in[FC_TX_BIT];
			rx_q <= fc_wdata_in[FC_RX_BIT];
		end
	end

	// Forced pause select; low means automatic resolution
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			forced_q <= FORCED_DEFAULT;
		end else if (load) begin
			forced_q <= forced_strap;
		end else if (fc_wr) begin
			forced_q <= fc_wdata_in[FC_FORCED_BIT];
		end
	end

	////////////////////////////////////////////////////////////////
	// PHY advertisement pause bits
	logic sym_q;
	logic asym_q;
	// Strap-derived advertisement defaults
	logic sym_def;
	logic asym_def;

	// Fiber mode or forced mode advertises no pause; otherwise symmetric plus duplex strap
	always_comb begin
		if (fx_mode) begin
			sym_def = FX_ADV_DEFAULT;
			asym_def = FX_ADV_DEFAULT;
		end else if (forced_strap) begin
			sym_def = 1'h0;
			asym_def = 1'h0;
		end else begin
			sym_def = SYM_AUTO_DEFAULT;
			asym_def = dup_strap;
		end
	end

	// Advertisement register bits
	always_ff @(posedge sys_clk_in) begin
		if (rst_in) begin
			sym_q <= SYM_AUTO_DEFAULT;
			asym_q <= DUP_DEFAULT;
		end else if (load) begin
			sym_q <= sym_def;
			asym_q <= asym_def;
		end else if (adv_wr) begin
			sym_q <= adv_wdata_in[ADV_SYM_BIT];
			asym_q <= adv_wdata_in[ADV_ASYM_BIT];
		end
	end

	////////////////////////////////////////////////////////////////
	// Outputs
	assign port2_backpressure_enable_out = bp_q;
	assign port2_pause_transmit_enable_out = tx_q;
	assign port2_pause_receive_enable_out = rx_q;
	assign port2_forced_pause_select_out = forced_q;
	assign adv_sym_pause_out = sym_q;
	assign adv_asym_pause_out = asym_q;
	assign load_done_out = (state_q == FCS_LOADED);

	////////////////////////////////////////////////////////////////
	// Checks
	chk_bp_load: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		load |=> (bp_q == $past(bp_strap)))
		else $error("backpressure enable not loaded from strap");

	chk_pause_load: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		load |=> (tx_q == $past(dup_strap)) && (rx_q == $past(dup_strap)))
		else $error("pause enables not loaded from duplex strap");

	chk_asym_load: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(load && !fx_mode && !forced_strap) |=> (asym_q == $past(dup_strap)) && sym_q)
		else $error("asymmetric advertisement not from duplex strap");

	chk_fx_adv: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(load && fx_mode) |=> (sym_q == FX_ADV_DEFAULT) && (asym_q == FX_ADV_DEFAULT)
			&& (bp_q == $past(bp_strap)))
		else $error("fiber mode altered advertisement defaults");

	chk_forced_load: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		load |=> (forced_q == $past(forced_strap)))
		else $error("forced pause select not loaded from strap");

	chk_forced_adv: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(load && !fx_mode && forced_strap) |=> !sym_q && !asym_q)
		else $error("forced strap did not clear advertisement");

	chk_write_keep: assert property (@(posedge sys_clk_in) disable iff (rst_in)
		(fc_wr_in && load_done_out) ##1 (!fc_wr_in) [*3] |->
			(bp_q == $past(fc_wdata_in[FC_BP_BIT], 3)) && load_done_out)
		else $error("software write did not persist");

	chk_load_time: assert property (@(posedge sys_clk_in)
		$fell(rst_in) |-> !load_done_out ##1 !load_done_out ##1 load ##1 load_done_out)
		else $error("strap load not at third edge after release");
endmodule

//--- tb_top.sv
// Self-checking bench for the port 2 flow-control strap default loader
`timescale 1ns/1ps
module tb_top;
	import fcs_pkg::*;
	logic sys_clk_in = 1'b0; // Bench clock
	logic rst_in = 1'b1; // Synchronous reset
	logic [STRAP_W-1:0] strap_q = 4'h3; // Strap pins and fiber mode
	logic fc_wr_in = 1'b0; // Flow-control write strobe
	logic [FC_W-1:0] fc_wdata_in = 4'h0; // Flow-control write word
	logic adv_wr_in = 1'b0; // Advertisement write strobe
	logic [ADV_W-1:0] adv_wdata_in = 2'h0; // Advertisement write word
	wire [FC_W-1:0] fc_seen; // Flow-control outputs in write-word order
	wire [ADV_W-1:0] adv_seen; // Advertisement outputs in write-word order
	logic load_done_out; // Straps taken
	int n_mismatch = 0; // Failed comparisons
	int comparisons = 0; // All comparisons
	int exp_fc; // Model flow-control word
	int exp_adv; // Model advertisement word

	// Compare one expected value with one seen value
	`define CHK(nm, e, g) begin comparisons++; if ((g) !== (e)) begin n_mismatch++; \
		$display("BAD %s expected %0h seen %0h", nm, e, g); end end

	//////////////////////////////////////////////////////////////////////////
	// Design under test
	fcs_top dut_u (.sys_clk_in(sys_clk_in), .rst_in(rst_in),
		.port2_backpressure_default_select_in(strap_q[STRAP_BP_BIT]),
		.port2_duplex_pause_default_select_in(strap_q[STRAP_DUP_BIT]),
		.port2_forced_pause_default_select_in(strap_q[STRAP_FORCED_BIT]),
		.phy_fx_mode_in(strap_q[STRAP_FX_BIT]), .fc_wr_in(fc_wr_in), .fc_wdata_in(fc_wdata_in),
		.adv_wr_in(adv_wr_in), .adv_wdata_in(adv_wdata_in),
		.port2_backpressure_enable_out(fc_seen[FC_BP_BIT]),
		.port2_pause_transmit_enable_out(fc_seen[FC_TX_BIT]),
		.port2_pause_receive_enable_out(fc_seen[FC_RX_BIT]),
		.port2_forced_pause_select_out(fc_seen[FC_FORCED_BIT]),
		.adv_sym_pause_out(adv_seen[ADV_SYM_BIT]), .adv_asym_pause_out(adv_seen[ADV_ASYM_BIT]),
		.load_done_out(load_done_out));

	// Free-running 100 MHz clock
	initial begin
		forever #5 sys_clk_in = ~sys_clk_in;
	end

	//////////////////////////////////////////////////////////////////////////
	// Compare all held bits with the model
	task automatic check_all();
		`CHK("backpressure", exp_fc & 1, fc_seen[FC_BP_BIT])
		`CHK("pause_txrx", (exp_fc >> 1) & 3, fc_seen[FC_RX_BIT:FC_TX_BIT])
		`CHK("forced", (exp_fc >> 3) & 1, fc_seen[FC_FORCED_BIT])
		`CHK("advert", exp_adv, adv_seen)
	endtask

	// Reset with given straps, then follow the load edge by edge
	task automatic reset_load(int s);
		int dup;
		logic [6:0] rst_exp;
		dup = (s >> STRAP_DUP_BIT) & 1;
		// Reset view: forced, rx, tx, backpressure, asym, sym, load done
		rst_exp = {FORCED_DEFAULT, DUP_DEFAULT, DUP_DEFAULT, BP_DEFAULT, DUP_DEFAULT, SYM_AUTO_DEFAULT, 1'b0};
		@(posedge sys_clk_in);
		rst_in <= 1'b1;
		strap_q <= s[STRAP_W-1:0];
		fc_wr_in <= 1'b1;
		fc_wdata_in <= 4'h0;
		repeat (2) @(posedge sys_clk_in);
		#1;
		// Writes during reset are ignored and reset values show
		`CHK("reset_state", rst_exp, ({fc_seen, adv_seen, load_done_out}))
		@(posedge sys_clk_in);
		rst_in <= 1'b0;
		// Strobe stays high through the settle cycles, which must refuse it
		repeat (2) @(posedge sys_clk_in);
		fc_wr_in <= 1'b0;
		#1;
		`CHK("done_early", 1'b0, load_done_out)
		`CHK("settle_hold", rst_exp[6:3], fc_seen)
		@(posedge sys_clk_in);
		#1;
		`CHK("done_late", 1'b1, load_done_out)
		// Model of the strap load
		exp_fc = (s & 1) | (dup << 1) | (dup << 2) | (((s >> STRAP_FORCED_BIT) & 1) << 3);
		exp_adv = ((s >> STRAP_FX_BIT) & 1) || ((s >> STRAP_FORCED_BIT) & 1) ? 0 : 1 | (dup << 1);
		check_all();
		// Pin changes after the load have no effect
		@(posedge sys_clk_in);
		strap_q <= ~s[STRAP_W-1:0];
		repeat (4) @(posedge sys_clk_in);
		#1;
		check_all();
	endtask

	// Back-to-back random writes to both words, strobes held high
	task automatic write_burst(int n);
		int fd;
		int ad;
		fd = $urandom % 16;
		ad = $urandom % 4;
		@(posedge sys_clk_in);
		fc_wr_in <= 1'b1;
		adv_wr_in <= 1'b1;
		fc_wdata_in <= fd[FC_W-1:0];
		adv_wdata_in <= ad[ADV_W-1:0];
		for (int i = 1; i <= n; i++) begin
			@(posedge sys_clk_in);
			exp_fc = fd;
			exp_adv = ad;
			if (i < n) begin
				fd = $urandom % 16;
				ad = $urandom % 4;
				fc_wdata_in <= fd[FC_W-1:0];
				adv_wdata_in <= ad[ADV_W-1:0];
			end else begin
				fc_wr_in <= 1'b0;
				adv_wr_in <= 1'b0;
			end
			#1;
			// Software writes replace the loaded defaults
			check_all();
		end
		repeat (3) @(posedge sys_clk_in);
		#1;
		check_all();
	endtask

	// Print the counts and the verdict, then stop
	task automatic give_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	//////////////////////////////////////////////////////////////////////////
	// Main sequence: every strap and fiber combination, then writes
	initial begin
		void'($urandom(13295));
		repeat (3) @(posedge sys_clk_in);
		for (int s = 0; s < 16; s++) begin
			reset_load(s);
			write_burst(3);
			$display("test straps %0h finished", s);
		end
		give_verdict();
	end
endmodule
